// file: test/rfq_rx_qual_tb.sv
// Purpose: self-checking bench of the receive frame qualifier
// Assumes: apb for settings, byte stream in, user sink model out
// Notes: settings change only between frames, with legal values
`timescale 1ns/1ps
module rfq_rx_qual_tb;
   logic clk = 1'b0, rst_n = 1'b0, sel = 1'b0, ena = 1'b0, wr = 1'b0, clr = 1'b1;
   logic [7:0] addr = 8'h00, d = 8'h00;
   logic [31:0] wd = 32'h0, rd, s0;
   logic v = 1'b0, sop = 1'b0, eop = 1'b0, perr;
   logic [31:0] prd;
   logic prdy, pse, rdy, ov, osop, oeop, oerr, bcrc, irq, done, err, obad;
   logic [15:0] mk;
   logic [7:0] od;
   int cnt, err_count = 0, checks_done = 0;
   logic bseen;
   // sticky copy of the one-cycle bad-crc pulse, cleared with the sink
   always @(posedge clk) bseen <= clr ? 1'b0 : (bseen | bcrc);
   rfq_rx_qual rfq_rx_qual_inst (.clk_sys_in(clk), .nrst_in(rst_n), .ce_in(1'b1),
      .psel_in(sel), .penable_in(ena), .pwrite_in(wr), .paddr_in(addr), .pwdata_in(wd),
      .prdata_out(prd), .pready_out(prdy), .pslverr_out(pse), .rx_in_valid_in(v),
      .rx_in_data_in(d), .rx_in_sop_in(sop), .rx_in_eop_in(eop), .rx_in_ready_out(rdy),
      .rx_out_valid_out(ov), .rx_out_data_out(od), .rx_out_sop_out(osop),
      .rx_out_eop_out(oeop), .rx_out_err_out(oerr), .rx_bad_crc_out(bcrc),
      .rx_marker_spacing_m1_out(mk), .irq_out(irq));
   rfq_user_sink rfq_user_sink_inst (.clk_in(clk), .clr_in(clr), .valid_in(ov), .data_in(od),
      .sop_in(osop), .eop_in(oeop), .err_in(oerr), .cnt_out(cnt), .err_out(err), .done_out(done),
      .order_bad_out(obad));
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] x);
      int n;
      @(posedge clk);
      {sel, ena, wr, addr, wd} <= {1'b1, 1'b0, w, a, x};
      @(posedge clk);
      ena <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!prdy && n < 20);
      {rd, perr} = {prd, pse};
      {sel, ena} <= 2'b00;
      if (n >= 20) begin
         chk("apb wait", 0, 1);
         close_out();
      end
   endtask : apb
   // reflected crc of body bytes 0..m-1, each byte equal to its index
   function automatic logic [31:0] fcs(input int m);
      logic [31:0] c;
      c = 32'hFFFFFFFF;
      for (int i = 0; i < m; i++) begin
         c = c ^ {24'h0, i[7:0]};
         for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ rfq_pkg::CRC_POLY : c >> 1;
      end
      return ~c;
   endfunction : fcs
   // n body bytes incl fcs; bad corrupts fcs; pre 1 spoils preamble, 2 the delimiter
   task automatic run(input int n, bad, pre, ec, ee);
      logic [31:0] f;
      int w;
      f = fcs(n - 4) ^ {31'h0, bad[0]};
      @(posedge clk);
      clr <= 1'b0;
      for (int k = 0; k < n + 8; k++) begin
         d <= k < 7 ? ((pre == 1 && k == 0) ? 8'h00 : 8'h55) : k == 7 ?
            (pre == 2 ? 8'hD4 : 8'hD5) : k < n + 4 ? 8'(k - 8) : f[8*(k-n-4) +: 8];
         {v, sop, eop} <= {1'b1, k == 0, k == n + 7};
         w = 0;
         do begin
            @(posedge clk);
            w++;
         end while (!rdy && w < 200);
         if (w >= 200) begin
            chk("ready wait", 0, 1);
            close_out();
         end
      end
      v <= 1'b0;
      w = 0;
      while (!done && w < 300) begin
         @(posedge clk);
         w++;
      end
      if (ec > 0 && !done) begin
         chk("eop wait", 0, 1);
         close_out();
      end
      chk("byte count", ec, cnt);
      chk("bad crc pin", bad, {31'h0, bseen});
      if (ec > 0) chk("eop error", ee, err);
      chk("byte order", 0, obad);
      clr <= 1'b1;
   endtask : run
   // ************************************************************
   // clock, reset, sequence
   // ************************************************************
   initial forever #25 clk = ~clk;
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk("marker pin", 32'h3FFF, {16'h0, mk});
      foreach (s0[i]) if (i < 5) begin
         apb(0, {3'h0, 5'(4 * i)}, 0);
         chk("reset value", i == 0 ? 4 : i == 1 ? 32'h2580 : i == 2 ? 32'h40 :
             i == 3 ? 32'h3FFF : 0, rd);
      end
      apb(0, 8'h40, 0);
      chk("unmapped err", 1, perr);
      run(80, 0, 0, 76, 0);
      run(80, 1, 0, 76, 1);
      apb(1, 8'h14, 1);
      repeat (2) @(posedge clk);
      chk("irq set", 1, irq);
      apb(1, 8'h10, 32'h3F);
      repeat (2) @(posedge clk);
      chk("irq clear", 0, irq);
      apb(1, 8'h00, 32'hC);
      apb(0, 8'h18, 0);
      s0 = rd;
      run(80, 1, 0, 76, 0);
      apb(0, 8'h18, 0);
      chk("good stats", s0[15:0] + 16'h1, rd[15:0]);
      chk("irq crc", 1, irq);
      apb(1, 8'h00, 32'h0);
      run(80, 0, 1, 80, 0);
      run(40, 0, 0, 0, 0);
      apb(1, 8'h00, 32'h1);
      run(80, 0, 1, 80, 1);
      apb(1, 8'h00, 32'h2);
      run(80, 0, 2, 80, 1);
      apb(1, 8'h00, 32'h4);
      apb(1, 8'h04, 32'h46);
      run(80, 0, 0, 70, 1);
      apb(1, 8'h04, 32'h2580);
      apb(1, 8'h08, 32'h60);
      run(80, 0, 0, 76, 1);
      apb(1, 8'h0C, 32'h100);
      // the write lands on the edge the task returns at; look one edge later
      @(posedge clk);
      chk("marker set", 32'h100, {16'h0, mk});
      close_out();
   end
endmodule : rfq_rx_qual_tb

// file: test/rfq_user_sink.sv
// Purpose: user side model of the segmented_packet_bus, one byte lane
// Assumes: no back-pressure exists, so every valid byte is taken
// Notes: body bytes are sent as their own index, so order is checkable
`timescale 1ns/1ps
module rfq_user_sink (
   // clock and control
   input wire logic clk_in,
   input wire logic clr_in,
   // delivered bytes
   input wire logic valid_in,
   input wire logic [7:0] data_in,
   input wire logic sop_in,
   input wire logic eop_in,
   input wire logic err_in,
   // observations
   output int cnt_out,
   output logic err_out,
   output logic done_out,
   output logic order_bad_out
);
   // count bytes; only the first 60 are compared since fcs bytes differ
   always_ff @(posedge clk_in) begin
      if (clr_in) begin
         cnt_out <= 0;
         err_out <= 1'b0;
         done_out <= 1'b0;
         order_bad_out <= 1'b0;
      end else if (valid_in) begin
         cnt_out <= cnt_out + 1;
         if (cnt_out < 60 && data_in !== cnt_out[7:0]) order_bad_out <= 1'b1;
         // start flag must mark the first byte and no other
         if ((cnt_out == 0) !== sop_in) order_bad_out <= 1'b1;
         if (eop_in) begin
            done_out <= 1'b1;
            err_out <= err_in;
         end
      end
   end
endmodule : rfq_user_sink

// file: verilog/rfq_crc32.sv
// Purpose: running frame check over body bytes, lsb first
// Assumes: init before the first body byte
// Notes: match is combinational and includes the byte being updated
`timescale 1ns/1ps
module rfq_crc32 (
   // clock and control
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic init_in,
   // data
   input wire logic upd_in,
   input wire logic [7:0] data_in,
   output logic match_out
);
   logic [31:0] crc_q, crc_d, nxt;
   // one byte of the reflected division per update
   always_comb begin
      nxt = crc_q ^ {24'h000000, data_in};
      for (int b = 0; b < 8; b++) begin
         nxt = nxt[0] ? ((nxt >> 1) ^ rfq_pkg::CRC_POLY) : (nxt >> 1);
      end
      crc_d = init_in ? rfq_pkg::CRC_INIT : (upd_in ? nxt : crc_q);
      match_out = ((upd_in ? nxt : crc_q) == rfq_pkg::CRC_RESIDUE);
   end
   // register
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         crc_q <= rfq_pkg::CRC_INIT;
      end else if (ce_in) begin
         crc_q <= crc_d;
      end
   end
endmodule : rfq_crc32

// file: verilog/rfq_hold_buf.sv
// Purpose: circular byte store that delays a frame until its length is known
// Assumes: caller never pops when empty nor pushes when full without popping
// Notes: clear wins over push and pop in the same cycle
`timescale 1ns/1ps
module rfq_hold_buf #(
   parameter int unsigned DW = 8,
   parameter int unsigned DEPTH = 64
) (
   // clock and control
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic clear_in,
   // write side
   input wire logic push_in,
   input wire logic [DW-1:0] push_data_in,
   // read side
   input wire logic pop_in,
   output logic [DW-1:0] pop_data_out,
   output logic [$clog2(DEPTH):0] count_out
);
   localparam int unsigned AW = $clog2(DEPTH);
   // refuse depths that the pointer wrap cannot serve
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("hold depth must be a power of two");
   end
   logic [DW-1:0] mem_q [DEPTH];
   logic [DW-1:0] mem_d [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   // pointer and storage next state
   always_comb begin
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (clear_in) begin
         wr_d = '0;
         rd_d = '0;
         cnt_d = '0;
      end else begin
         if (push_in) begin
            mem_d[wr_q] = push_data_in;
            wr_d = wr_q + 1'b1;
         end
         if (pop_in) begin
            rd_d = rd_q + 1'b1;
         end
         cnt_d = cnt_q + {{AW{1'b0}}, push_in} - {{AW{1'b0}}, pop_in};
      end
   end
   // register, frozen while the clock enable is low
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < int'(DEPTH); i++) begin
            mem_q[i] <= '0;
         end
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else if (ce_in) begin
         mem_q <= mem_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end
   assign pop_data_out = mem_q[rd_q];
   assign count_out = cnt_q;
endmodule : rfq_hold_buf

// file: verilog/rfq_pkg.sv
// Purpose: shared constants for the receive frame qualifier
// Assumes: byte-wide line stream, APB register access
// Notes: every offset and non-zero reset value of the block lives here; the checks repeat some counts as literals
package rfq_pkg;
   // ************************************************************
   // stream and frame geometry
   // ************************************************************
   localparam int unsigned DATA_W = 8;
   localparam int unsigned LEN_W = 16;
   localparam int unsigned HOLD_DEPTH = 64;
   localparam logic [15:0] RUNT_LEN = 16'h0040;
   localparam logic [15:0] SHORT_KEEP_LEN = 16'h0008;
   localparam logic [6:0] FCS_BYTES = 7'h04;
   localparam logic [2:0] PRE_LAST_IDX = 3'h7;
   localparam logic [7:0] PRE_BYTE = 8'h55;
   localparam logic [7:0] SFD_BYTE = 8'hD5;
   // ************************************************************
   // crc-32, reflected form
   // ************************************************************
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
   localparam logic [31:0] CRC_POLY = 32'hEDB88320;
   localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_MAXLEN = 8'h04;
   localparam logic [7:0] ADDR_MINLEN = 8'h08;
   localparam logic [7:0] ADDR_MARKER = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_MASK = 8'h14;
   localparam logic [7:0] ADDR_STATS = 8'h18;
   localparam int unsigned CTRL_PRE_BIT = 0;
   localparam int unsigned CTRL_SFD_BIT = 1;
   localparam int unsigned CTRL_STRIP_BIT = 2;
   localparam int unsigned CTRL_MASK_BIT = 3;
   localparam logic [3:0] CTRL_RST = 4'h4;
   localparam logic [14:0] MAXLEN_RST = 15'h2580;
   localparam logic [7:0] MINLEN_RST = 8'h40;
   localparam logic [15:0] MARKER_RST = 16'h3FFF;
   // ************************************************************
   // event bits of status and mask
   // ************************************************************
   localparam int unsigned EV_W = 6;
   localparam int unsigned EV_BAD_CRC = 0;
   localparam int unsigned EV_OVER = 1;
   localparam int unsigned EV_UNDER = 2;
   localparam int unsigned EV_RUNT = 3;
   localparam int unsigned EV_PRE = 4;
   localparam int unsigned EV_SFD = 5;
   // ************************************************************
   // receive states, gray along idle-pre-body-flush
   // ************************************************************
   typedef enum logic [2:0] {
      RFQ_IDLE = 3'b000,
      RFQ_PRE = 3'b001,
      RFQ_BODY = 3'b011,
      RFQ_FLUSH = 3'b010,
      RFQ_DISCARD = 3'b111
   } rfq_state_t;
endpackage : rfq_pkg

// file: verilog/rfq_rx_qual.sv
// Purpose: receive frame qualification: preamble, delimiter, crc, length
// Assumes: line bytes arrive on clk_sys_in with sop on the first preamble byte
// Notes: frames are held 64 bytes deep so runts vanish from the user side, seen only in the status runt bit and the bad count
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module rfq_rx_qual (
   // clock, reset, enable
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // line side byte stream
   input wire logic rx_in_valid_in,
   input wire logic [7:0] rx_in_data_in,
   input wire logic rx_in_sop_in,
   input wire logic rx_in_eop_in,
   output logic rx_in_ready_out,
   // segmented_packet_bus user side, one byte lane
   output logic rx_out_valid_out,
   output logic [7:0] rx_out_data_out,
   output logic rx_out_sop_out,
   output logic rx_out_eop_out,
   output logic rx_out_err_out,
   // status
   output logic rx_bad_crc_out,
   output logic [15:0] rx_marker_spacing_m1_out,
   output logic irq_out
);
   // ************************************************************
   // reset release
   // ************************************************************
   logic rst_meta_q, rst_n;
   // async assert, release after two edges
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end
   // ************************************************************
   // registers
   // ************************************************************
   localparam int unsigned EW = rfq_pkg::EV_W;
   logic [3:0] ctrl_q, ctrl_d;
   logic [14:0] max_q, max_d;
   logic [7:0] min_q, min_d;
   logic [15:0] marker_q, marker_d;
   logic [EW-1:0] status_q, status_d, mask_q, mask_d, ev;
   logic [15:0] good_q, good_d, bad_q, bad_d;
   logic good_inc, bad_inc;
   logic [31:0] rdata_q, rdata_d;
   logic rdy_q, rdy_d, slverr_q, slverr_d, irq_q, irq_d;
   logic apb_acc, apb_done;
   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == rfq_pkg::ADDR_CTRL) || (a == rfq_pkg::ADDR_MAXLEN) ||
         (a == rfq_pkg::ADDR_MINLEN) || (a == rfq_pkg::ADDR_MARKER) ||
         (a == rfq_pkg::ADDR_STATUS) || (a == rfq_pkg::ADDR_MASK) ||
         (a == rfq_pkg::ADDR_STATS);
   endfunction : reg_hit
   // answer one cycle into access; writes land on the sampling edge
   always_comb begin
      apb_acc = psel_in & penable_in & ~rdy_q;
      apb_done = psel_in & penable_in & rdy_q & pwrite_in & reg_hit(paddr_in);
      rdy_d = apb_acc;
      slverr_d = apb_acc & ~reg_hit(paddr_in); // error only stands with pready
      rdata_d = rdata_q;
      if (apb_acc) begin
         case (paddr_in)
            rfq_pkg::ADDR_CTRL: rdata_d = {28'h0000000, ctrl_q};
            rfq_pkg::ADDR_MAXLEN: rdata_d = {17'h00000, max_q};
            rfq_pkg::ADDR_MINLEN: rdata_d = {24'h000000, min_q};
            rfq_pkg::ADDR_MARKER: rdata_d = {16'h0000, marker_q};
            rfq_pkg::ADDR_STATUS: rdata_d = {26'h0000000, status_q};
            rfq_pkg::ADDR_MASK: rdata_d = {26'h0000000, mask_q};
            rfq_pkg::ADDR_STATS: rdata_d = {bad_q, good_q};
            default: rdata_d = 32'h00000000;
         endcase
      end
      ctrl_d = ctrl_q;
      max_d = max_q;
      min_d = min_q;
      marker_d = marker_q;
      mask_d = mask_q;
      if (apb_done) begin
         case (paddr_in)
            rfq_pkg::ADDR_CTRL: ctrl_d = pwdata_in[3:0];
            rfq_pkg::ADDR_MAXLEN: max_d = pwdata_in[14:0];
            rfq_pkg::ADDR_MINLEN: min_d = pwdata_in[7:0];
            rfq_pkg::ADDR_MARKER: marker_d = pwdata_in[15:0];
            rfq_pkg::ADDR_MASK: mask_d = pwdata_in[EW-1:0];
            default: ctrl_d = ctrl_q;
         endcase
      end
      // set wins over write-one-to-clear
      status_d = status_q;
      if (apb_done && paddr_in == rfq_pkg::ADDR_STATUS) begin
         status_d = status_q & ~pwdata_in[EW-1:0];
      end
      status_d = status_d | ev;
      irq_d = |(status_d & mask_d);
      good_d = good_q + {15'h0000, good_inc};
      bad_d = bad_q + {15'h0000, bad_inc};
   end
   // register file storage
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= rfq_pkg::CTRL_RST;
         max_q <= rfq_pkg::MAXLEN_RST;
         min_q <= rfq_pkg::MINLEN_RST;
         marker_q <= rfq_pkg::MARKER_RST;
         status_q <= '0;
         mask_q <= '0;
         good_q <= 16'h0000;
         bad_q <= 16'h0000;
         rdata_q <= 32'h00000000;
         rdy_q <= 1'b0;
         slverr_q <= 1'b0;
         irq_q <= 1'b0;
      end else if (ce_in) begin
         ctrl_q <= ctrl_d;
         max_q <= max_d;
         min_q <= min_d;
         marker_q <= marker_d;
         status_q <= status_d;
         mask_q <= mask_d;
         good_q <= good_d;
         bad_q <= bad_d;
         rdata_q <= rdata_d;
         rdy_q <= rdy_d;
         slverr_q <= slverr_d;
         irq_q <= irq_d;
      end
   end
   // ************************************************************
   // frame path
   // ************************************************************
   rfq_pkg::rfq_state_t st_q, st_d;
   logic [15:0] len_q, len_d;
   logic [2:0] pidx_q, pidx_d;
   logic pre_err_q, pre_err_d, sfd_err_q, sfd_err_d, trunc_q, trunc_d;
   logic first_q, first_d, err_fin_q, err_fin_d, ordy_q, ordy_d;
   logic [6:0] flush_q, flush_d, cnt, cnt_after;
   logic ov_q, ov_d, osop_q, osop_d, oeop_q, oeop_d, oerr_q, oerr_d;
   logic [7:0] od_q, od_d, pop_data;
   logic bcrc_q, bcrc_d;
   logic acc, push, pop, clr, crc_init, crc_upd, crc_ok, fin;
   logic runt, strip, crc_bad, over, under, pre_e, sfd_e;
   rfq_hold_buf #(
      .DW(rfq_pkg::DATA_W),
      .DEPTH(rfq_pkg::HOLD_DEPTH)
   ) u_hold (
      .clk_in(clk_sys_in),
      .rst_n_in(rst_n),
      .ce_in(ce_in),
      .clear_in(clr),
      .push_in(push),
      .push_data_in(rx_in_data_in),
      .pop_in(pop),
      .pop_data_out(pop_data),
      .count_out(cnt)
   );
   rfq_crc32 u_crc (
      .clk_in(clk_sys_in),
      .rst_n_in(rst_n),
      .ce_in(ce_in),
      .init_in(crc_init),
      .upd_in(crc_upd),
      .data_in(rx_in_data_in),
      .match_out(crc_ok)
   );
   // sequencing; input stalls only while the held tail drains
   always_comb begin
      st_d = st_q;
      len_d = len_q;
      pidx_d = pidx_q;
      pre_err_d = pre_err_q;
      sfd_err_d = sfd_err_q;
      trunc_d = trunc_q;
      first_d = first_q;
      flush_d = flush_q;
      err_fin_d = err_fin_q;
      push = 1'b0;
      pop = 1'b0;
      clr = 1'b0;
      crc_init = 1'b0;
      crc_upd = 1'b0;
      fin = 1'b0;
      ev = '0;
      good_inc = 1'b0;
      bad_inc = 1'b0;
      bcrc_d = 1'b0;
      oeop_d = 1'b0;
      oerr_d = 1'b0;
      acc = rx_in_valid_in & ordy_q;
      case (st_q)
         rfq_pkg::RFQ_IDLE: begin
            if (acc && rx_in_sop_in) begin
               st_d = rfq_pkg::RFQ_PRE;
               pidx_d = 3'h1;
               pre_err_d = (rx_in_data_in != rfq_pkg::PRE_BYTE);
               sfd_err_d = 1'b0;
               len_d = 16'h0000;
               trunc_d = 1'b0;
               first_d = 1'b1;
               crc_init = 1'b1;
               clr = 1'b1;
            end
         end
         rfq_pkg::RFQ_PRE: begin
            if (acc) begin
               if (pidx_q == rfq_pkg::PRE_LAST_IDX) begin
                  sfd_err_d = (rx_in_data_in != rfq_pkg::SFD_BYTE);
                  st_d = rfq_pkg::RFQ_BODY;
               end else begin
                  pre_err_d = pre_err_q | (rx_in_data_in != rfq_pkg::PRE_BYTE);
                  pidx_d = pidx_q + 3'h1;
               end
            end
         end
         rfq_pkg::RFQ_BODY: begin
            if (acc) begin
               push = 1'b1;
               crc_upd = 1'b1;
               len_d = len_q + 16'h0001;
               pop = (cnt == 7'(rfq_pkg::HOLD_DEPTH));
               if (!rx_in_eop_in && len_d == {1'b0, max_q}) begin
                  st_d = rfq_pkg::RFQ_DISCARD;
                  trunc_d = 1'b1;
               end
            end
         end
         rfq_pkg::RFQ_DISCARD: begin
            pop = 1'b0;
         end
         rfq_pkg::RFQ_FLUSH: begin
            pop = 1'b1;
            flush_d = flush_q - 7'h01;
            if (flush_q == 7'h01) begin
               oeop_d = 1'b1;
               oerr_d = err_fin_q;
               clr = 1'b1;
               st_d = rfq_pkg::RFQ_IDLE;
            end
         end
         default: st_d = rfq_pkg::RFQ_IDLE;
      endcase
      if (acc && rx_in_eop_in && st_q != rfq_pkg::RFQ_IDLE && st_q != rfq_pkg::RFQ_FLUSH) begin
         fin = 1'b1;
      end
      if (acc && rx_in_eop_in && st_q == rfq_pkg::RFQ_IDLE && rx_in_sop_in) begin
         fin = 1'b1;
      end
      // verdict at end of frame
      cnt_after = cnt + {6'h00, push} - {6'h00, pop};
      runt = (len_d < rfq_pkg::RUNT_LEN);
      strip = ctrl_q[rfq_pkg::CTRL_STRIP_BIT] & ~trunc_d &
         (len_d > rfq_pkg::SHORT_KEEP_LEN);
      crc_bad = ~trunc_d & ~crc_ok;
      over = trunc_d;
      under = (len_d < {8'h00, min_q});
      pre_e = pre_err_d & ctrl_q[rfq_pkg::CTRL_PRE_BIT];
      sfd_e = sfd_err_d & ctrl_q[rfq_pkg::CTRL_SFD_BIT];
      if (fin) begin
         if (runt) begin
            clr = 1'b1;
            st_d = rfq_pkg::RFQ_IDLE;
            ev[rfq_pkg::EV_RUNT] = 1'b1;
            bad_inc = 1'b1;
         end else begin
            st_d = rfq_pkg::RFQ_FLUSH;
            flush_d = cnt_after - (strip ? rfq_pkg::FCS_BYTES : 7'h00);
            err_fin_d = (crc_bad & ~ctrl_q[rfq_pkg::CTRL_MASK_BIT]) | over | under |
               pre_e | sfd_e;
            ev[rfq_pkg::EV_BAD_CRC] = crc_bad;
            ev[rfq_pkg::EV_OVER] = over;
            ev[rfq_pkg::EV_UNDER] = under;
            ev[rfq_pkg::EV_PRE] = pre_e;
            ev[rfq_pkg::EV_SFD] = sfd_e;
            bcrc_d = crc_bad;
            good_inc = ~(over | under | pre_e | sfd_e) &
               (~crc_bad | ctrl_q[rfq_pkg::CTRL_MASK_BIT]);
            bad_inc = ~good_inc;
         end
      end
      ov_d = pop;
      od_d = pop ? pop_data : od_q;
      osop_d = pop & first_q;
      if (pop) begin
         first_d = 1'b0;
      end
      ordy_d = (st_d != rfq_pkg::RFQ_FLUSH);
   end
   // frame path registers
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= rfq_pkg::RFQ_IDLE;
         len_q <= 16'h0000;
         pidx_q <= 3'h0;
         pre_err_q <= 1'b0;
         sfd_err_q <= 1'b0;
         trunc_q <= 1'b0;
         first_q <= 1'b0;
         flush_q <= 7'h00;
         err_fin_q <= 1'b0;
         ordy_q <= 1'b0;
         ov_q <= 1'b0;
         od_q <= 8'h00;
         osop_q <= 1'b0;
         oeop_q <= 1'b0;
         oerr_q <= 1'b0;
         bcrc_q <= 1'b0;
      end else if (ce_in) begin
         st_q <= st_d;
         len_q <= len_d;
         pidx_q <= pidx_d;
         pre_err_q <= pre_err_d;
         sfd_err_q <= sfd_err_d;
         trunc_q <= trunc_d;
         first_q <= first_d;
         flush_q <= flush_d;
         err_fin_q <= err_fin_d;
         ordy_q <= ordy_d;
         ov_q <= ov_d;
         od_q <= od_d;
         osop_q <= osop_d;
         oeop_q <= oeop_d;
         oerr_q <= oerr_d;
         bcrc_q <= bcrc_d;
      end
   end
   // ************************************************************
   // outputs
   // ************************************************************
   assign prdata_out = rdata_q;
   assign pready_out = rdy_q;
   assign pslverr_out = slverr_q;
   assign rx_in_ready_out = ordy_q;
   assign rx_out_valid_out = ov_q;
   assign rx_out_data_out = od_q;
   assign rx_out_sop_out = osop_q;
   assign rx_out_eop_out = oeop_q;
   assign rx_out_err_out = oerr_q;
   assign rx_bad_crc_out = bcrc_q;
   assign rx_marker_spacing_m1_out = marker_q;
   assign irq_out = irq_q;
   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n || !ce_in);
   AST_PRE_OFF: assert property (fin && !ctrl_q[0] |=> !status_q[4] || $past(status_q[4]))
      else $error("preamble flagged while check off");
   AST_SFD_OFF: assert property (fin && !ctrl_q[1] && !status_q[5] |=> !status_q[5])
      else $error("delimiter flagged while check off");
   AST_STRIP: assert property (fin && !runt && strip |=> flush_q == $past(cnt_after) - 7'h04)
      else $error("strip count wrong");
   AST_SHORT_KEEP: assert property (fin && len_d <= 16'h0008 |-> !strip)
      else $error("short frame stripped");
   AST_CRC_FLAG: assert property (fin && !runt && crc_bad && !ctrl_q[3]
      |=> (!rx_out_eop_out) [*1] ##[1:70] (rx_out_eop_out && rx_out_err_out))
      else $error("crc error not flagged at eop");
   AST_CRC_MASK: assert property (fin && !runt && ctrl_q[3] && !over && !under && !pre_e && !sfd_e
      |=> !err_fin_q)
      else $error("masked crc error flagged");
   AST_BAD_PIN: assert property (fin && !runt && crc_bad |=> rx_bad_crc_out)
      else $error("bad crc pin not pulsed");
   AST_CRC_STATS: assert property (fin && !runt && crc_bad && !under && !pre_e && !sfd_e
      |=> good_q == $past(good_q) + {15'h0000, $past(ctrl_q[3])})
      else $error("good frame count wrong after crc error");
   AST_TRUNC: assert property ($rose(trunc_q) |-> len_q == {1'b0, max_q})
      else $error("truncation at wrong length");
   AST_RUNT: assert property (fin && runt |=> st_q == rfq_pkg::RFQ_IDLE && !rx_out_valid_out
      ##1 !rx_out_valid_out)
      else $error("runt frame delivered");
   AST_UNDER: assert property (fin && !runt && under |=> err_fin_q)
      else $error("undersize not flagged");
   AST_MARKER: assert property (apb_done && paddr_in == rfq_pkg::ADDR_MARKER
      |=> {16'h0000, rx_marker_spacing_m1_out} == ($past(pwdata_in) & 32'h0000FFFF))
      else $error("marker spacing output differs");
endmodule : rfq_rx_qual
